// File: include/flash_pins_regs.svh
// Constants for the serial flash pin control block.
// Assumes a 50 MHz core clock; included by bare name.
`ifndef FLASH_PINS_REGS_SVH
`define FLASH_PINS_REGS_SVH

// ----------------------------------------
// Command opcodes
// ----------------------------------------
`define CMD_ERASE_PAGE   8'h81
`define CMD_ERASE_4K     8'h20
`define CMD_ERASE_32K    8'h52
`define CMD_ERASE_CHIP   8'h60
`define CMD_READ_STATUS  8'h05

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define CMD_BITS         6'd8
`define ADDR_FRAME_BITS  6'd32
`define ADDR_WIDTH       17
`define STATUS_BUSY_BIT  0
`define STATUS_LOCK_BIT  1
`define STATUS_REF_BIT   2

// ----------------------------------------
// Timing (erase times are plain defaults)
// ----------------------------------------
`define CLK_MHZ          50
`define ERASE_PAGE_US    100
`define ERASE_4K_US      200
`define ERASE_32K_US     400
`define ERASE_CHIP_US    800
`define PROT_BASE_RESET  17'h10000

`endif

// File: include/flash_pins_pkg.sv
// Types shared by the serial flash pin control block.
// Assumes the constants header is compiled alongside.
`default_nettype none
package flash_pins_pkg;

  // Erase granularity levels
  typedef enum logic [1:0] {
    ERASE_PAGE = 2'b00,
    ERASE_4K   = 2'b01,
    ERASE_32K  = 2'b10,
    ERASE_CHIP = 2'b11
  } erase_kind_e;

  // One erase request towards the array
  typedef struct packed {
    erase_kind_e kind;
    logic [16:0] addr;
  } erase_req_s;

  // Engine states
  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_RUN  = 2'b01,
    ENG_DONE = 2'b10
  } eng_state_e;

endpackage
`default_nettype wire

// File: rtl/flash_sync.sv
// Two flip-flop level synchroniser.
// Assumes the input is a slow level from another domain.
`default_nettype none
module flash_sync #(
  parameter int W     = 1,
  parameter bit RSTV  = 1'b0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_reg;  // First stage, read only by second

  // ----------------------------------------
  // Two stages
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_reg <= {W{RSTV}};
      q_o      <= {W{RSTV}};
    end
    else
    begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// File: rtl/flash_pin_ctrl.sv
// Serial flash host interface pin control: pause, lock, erase engine.
// Assumes sck_i is the link clock from the host; clk_i is the core clock.
// Pull-ups on the pause and lock pads resolve floating pins to high.
//
// Notes on behaviour
// [RL1] Pause suspends transfer, keeps selection, no reset
// [RL2] Paused: ignore clock edges and input data
// [RL3] Paused: serial output released
// [RL4] Host pauses only selected with clock low
// [RL5] Pause never disturbs running erase
// [RL6] Active-low lock enables hardware protection
// [RL7] Floating lock reads deasserted via pull-up
// [RL8] Floating pause reads deasserted via pull-up
// [RL9] Four erase granularities including whole chip
// [RL10] Capture on rising, launch on falling
// [RL11] Deselected: ignore input, output released
// [RL12] Resume at same bit after pause
`include "flash_pins_regs.svh"
`default_nettype none
module flash_pin_ctrl
  import flash_pins_pkg::*;
#(
  parameter int PAGE_CYC  = `ERASE_PAGE_US * `CLK_MHZ,
  parameter int BLK4_CYC  = `ERASE_4K_US * `CLK_MHZ,
  parameter int BLK32_CYC = `ERASE_32K_US * `CLK_MHZ,
  parameter int CHIP_CYC  = `ERASE_CHIP_US * `CLK_MHZ
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   sck_i,
  input  wire logic                   cs_n_i,
  input  wire logic                   si_i,
  input  wire logic                   hold_n_i,
  input  wire logic                   lock_n_i,
  input  wire logic [`ADDR_WIDTH-1:0] prot_base_i,
  output logic                        so_o,
  output logic                        so_oe_n_o,
  output logic                        busy_o,
  output logic                        lock_active_o,
  output logic                        erase_start_o,
  output erase_req_s                  erase_req_o,
  output logic                        erase_done_o,
  output logic                        erase_refused_o
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Cycle count for one erase kind
  function automatic logic [31:0] erase_cycles(input erase_kind_e k);
    case (k)
      ERASE_PAGE: erase_cycles = 32'(PAGE_CYC);
      ERASE_4K:   erase_cycles = 32'(BLK4_CYC);
      ERASE_32K:  erase_cycles = 32'(BLK32_CYC);
      default:    erase_cycles = 32'(CHIP_CYC);
    endcase
  endfunction

  // ----------------------------------------
  // Link domain (sck_i)
  // ----------------------------------------
  logic        pause_act;       // Pause in force while selected
  logic        link_rst;        // Sets the frame start marker when deselected
  logic        first_reg;       // Next rising edge is frame bit 0
  logic [5:0]  count_reg;       // Bits captured this frame, saturating
  logic [7:0]  cmd_reg;         // Captured opcode
  logic [23:0] addr_reg;        // Captured address bits
  logic        so_reg;          // Launched output bit
  logic [2:0]  out_idx;         // Bit index within status byte
  logic [2:0]  status_link;     // Core status seen on link clock
  logic [7:0]  status_byte;     // Byte shifted out on status read

  // Pad pull-up: only a driven low pauses; z or high never does
  assign pause_act = (hold_n_i == 1'b0) && !cs_n_i; // [RL8] [RL1]
  // Host only lowers the pause pin while sck is low, so edges stay clean
  assign link_rst  = cs_n_i | rst_i; // [RL4] [RL11]

  // Frame start marker, set whenever deselected
  always_ff @(posedge sck_i or posedge link_rst)
  begin
    if (link_rst)
      first_reg <= 1'b1;
    else if (!pause_act)
      first_reg <= 1'b0; // [RL2]
  end

  // Bit counter; kept after deselect so the core can read it
  always_ff @(posedge sck_i or posedge rst_i)
  begin
    if (rst_i)
      count_reg <= 6'h00;
    else if (cs_n_i || pause_act)
      count_reg <= count_reg; // [RL2] [RL12] [RL11]
    else if (first_reg)
      count_reg <= 6'h01;
    else if (count_reg != 6'h3f)
      count_reg <= count_reg + 6'h01;
  end

  // Opcode and address capture on rising edge
  always_ff @(posedge sck_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cmd_reg  <= 8'h00;
      addr_reg <= 24'h000000;
    end
    else if (!cs_n_i && !pause_act) // [RL2] [RL10] [RL11]
    begin
      if (first_reg || count_reg < `CMD_BITS)
        cmd_reg <= {cmd_reg[6:0], si_i};
      else if (count_reg < `ADDR_FRAME_BITS)
        addr_reg <= {addr_reg[22:0], si_i};
    end
  end

  // Core status brought onto the link clock
  flash_sync #(.W(3), .RSTV(1'b0)) u_status_sync (
    .clk_i (sck_i),
    .rst_i (rst_i),
    .d_i   ({erase_refused_o, lock_active_o, busy_o}),
    .q_o   (status_link)
  );

  assign status_byte = {5'h00, status_link};
  assign out_idx     = 3'(count_reg - `CMD_BITS);

  // Output launch on falling edge, MSB first
  always_ff @(negedge sck_i or posedge rst_i)
  begin
    if (rst_i)
      so_reg <= 1'b0;
    else if (!cs_n_i && !pause_act && cmd_reg == `CMD_READ_STATUS
             && count_reg >= `CMD_BITS) // [RL10] [RL2]
      so_reg <= status_byte[3'h7 - out_idx];
  end

  assign so_o      = so_reg;
  // Release while deselected or paused
  assign so_oe_n_o = cs_n_i | pause_act; // [RL3] [RL11]

  // ----------------------------------------
  // Core domain (clk_i)
  // ----------------------------------------
  logic        cs_n_sync;       // Select seen on core clock
  logic        cs_n_prev_reg;   // Previous synced select
  logic        lock_n_sync;     // Lock pin seen on core clock
  logic        frame_end;       // Rising select: link state quiet
  erase_kind_e kind_dec;        // Decoded erase kind
  logic        is_erase;        // Opcode is one of the erases
  logic        protected_hit;   // Request touches a locked area
  eng_state_e  state_reg;       // Engine state
  logic [31:0] timer_reg;       // Erase time remaining
  erase_req_s  req_next;        // Request formed at frame end

  // Reset loads the synchroniser high, matching an idle deselected bus
  flash_sync #(.W(1), .RSTV(1'b1)) u_cs_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (cs_n_i),
    .q_o   (cs_n_sync)
  );

  // Floating lock pad resolves high: protection off
  flash_sync #(.W(1), .RSTV(1'b1)) u_lock_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (lock_n_i),
    .q_o   (lock_n_sync)
  );

  // Select edge history
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      cs_n_prev_reg <= 1'b1;
    else
      cs_n_prev_reg <= cs_n_sync;
  end

  // Link registers are static once select has risen: safe multi-bit read
  assign frame_end = cs_n_sync && !cs_n_prev_reg;

  // Opcode decode into the three granularities plus whole chip
  always_comb
  begin
    is_erase = 1'b1;
    kind_dec = ERASE_PAGE;
    case (cmd_reg)
      `CMD_ERASE_PAGE: kind_dec = ERASE_PAGE; // [RL9]
      `CMD_ERASE_4K:   kind_dec = ERASE_4K;   // [RL9]
      `CMD_ERASE_32K:  kind_dec = ERASE_32K;  // [RL9]
      `CMD_ERASE_CHIP: kind_dec = ERASE_CHIP; // [RL9]
      default:         is_erase = 1'b0;
    endcase
  end

  // Chip erase needs only the opcode; the others need a full address
  assign req_next = '{kind: kind_dec, addr: addr_reg[`ADDR_WIDTH-1:0]};

  assign lock_active_o = !lock_n_sync; // [RL6] [RL7]
  // Lock guards everything at or above the base; chip erase always hits
  assign protected_hit = lock_active_o
                         && (kind_dec == ERASE_CHIP || req_next.addr >= prot_base_i); // [RL6]

  // Erase engine; runs on core clock, blind to pause, and to select once running
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg     <= ENG_IDLE;
      timer_reg     <= 32'h00000000;
      erase_start_o <= 1'b0;
      erase_done_o  <= 1'b0;
      erase_req_o   <= '0;
    end
    else
    begin
      erase_start_o <= 1'b0;
      erase_done_o  <= 1'b0;
      case (state_reg)
        ENG_IDLE:
        begin
          // Short or refused frames leave the engine idle
          if (frame_end && is_erase && !protected_hit
              && (kind_dec == ERASE_CHIP ? count_reg == `CMD_BITS
                                         : count_reg == `ADDR_FRAME_BITS))
          begin
            state_reg     <= ENG_RUN;
            timer_reg     <= erase_cycles(kind_dec);
            erase_req_o   <= req_next;
            erase_start_o <= 1'b1;
          end
        end
        ENG_RUN:
        begin
          // Self-timed: pause on the link cannot reach here
          if (timer_reg <= 32'h00000001) // [RL5]
            state_reg <= ENG_DONE;
          else
            timer_reg <= timer_reg - 32'h00000001; // [RL5]
        end
        ENG_DONE:
        begin
          erase_done_o <= 1'b1;
          state_reg    <= ENG_IDLE;
        end
        default:
          state_reg <= ENG_IDLE;
      endcase
    end
  end

  assign busy_o = (state_reg != ENG_IDLE);

  // Sticky refusal flag; a new accepted erase clears it, refusal wins
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      erase_refused_o <= 1'b0;
    else if (frame_end && is_erase && state_reg == ENG_IDLE && protected_hit)
      erase_refused_o <= 1'b1; // [RL6]
    else if (erase_start_o)
      erase_refused_o <= 1'b0;
  end

endmodule
`default_nettype wire

// File: verification/flash_pin_ctrl_properties.sv
// Checker on the pin control ports.
// Assumes the package and constants header are compiled first.
`include "flash_pins_regs.svh"
`default_nettype none
module flash_pin_ctrl_checker
  import flash_pins_pkg::*;
(
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic                   sck_i,
  input wire logic                   cs_n_i,
  input wire logic                   si_i,
  input wire logic                   hold_n_i,
  input wire logic                   lock_n_i,
  input wire logic [`ADDR_WIDTH-1:0] prot_base_i,
  input wire logic                   so_o,
  input wire logic                   so_oe_n_o,
  input wire logic                   busy_o,
  input wire logic                   lock_active_o,
  input wire logic                   erase_start_o,
  input wire erase_req_s             erase_req_o,
  input wire logic                   erase_done_o,
  input wire logic                   erase_refused_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Core domain only: link side seen via pins
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_paused; !cs_n_i && !hold_n_i; endsequence
  sequence s_run; busy_o [*8]; endsequence
  property p_cs_off; cs_n_i |-> so_oe_n_o; endproperty
  property p_pause_off; s_paused |-> so_oe_n_o; endproperty
  property p_drive; !cs_n_i && hold_n_i |-> !so_oe_n_o; endproperty
  property p_pause_so; s_paused [*2] |-> $stable(so_o); endproperty
  property p_lock_on; !lock_n_i [*4] |-> lock_active_o; endproperty
  property p_lock_off; lock_n_i [*4] |-> !lock_active_o; endproperty
  property p_start; erase_start_o |-> s_run; endproperty
  property p_pulse; erase_start_o |=> !erase_start_o; endproperty
  property p_done; erase_done_o |=> !busy_o && !erase_done_o; endproperty
  property p_clear; erase_start_o |=> !erase_refused_o; endproperty
  a_cs_off: assert property (p_cs_off)
    else $error("output driven while deselected");
  a_pause_off: assert property (p_pause_off)
    else $error("output driven while paused");
  a_drive: assert property (p_drive)
    else $error("output released while selected");
  a_pause_so: assert property (p_pause_so)
    else $error("output moved while paused");
  a_lock_on: assert property (p_lock_on)
    else $error("lock not active");
  a_lock_off: assert property (p_lock_off)
    else $error("lock active while released");
  a_start: assert property (p_start)
    else $error("erase run too short");
  a_pulse: assert property (p_pulse)
    else $error("start pulse too long");
  a_done: assert property (p_done)
    else $error("busy after done");
  a_clear: assert property (p_clear)
    else $error("refusal kept after start");
endmodule
bind flash_pin_ctrl flash_pin_ctrl_checker chk (.clk_i(clk_i), .rst_i(rst_i),
  .sck_i(sck_i), .cs_n_i(cs_n_i), .si_i(si_i), .hold_n_i(hold_n_i),
  .lock_n_i(lock_n_i), .prot_base_i(prot_base_i), .so_o(so_o),
  .so_oe_n_o(so_oe_n_o), .busy_o(busy_o), .lock_active_o(lock_active_o),
  .erase_start_o(erase_start_o), .erase_req_o(erase_req_o),
  .erase_done_o(erase_done_o), .erase_refused_o(erase_refused_o));
`default_nettype wire

// File: verification/spi_host_model.sv
// Host side of the link: clock only within frames, mode 0.
// Assumes the bench resolves the pause pad with a pull-up.
`default_nettype none
module spi_host_model (
  output var logic sck_o,
  output var logic cs_n_o,
  output var logic si_o,
  output var logic hold_o,
  input  wire logic so_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    hold_o = 1'b0;
  end
  // One frame; pause before bit hp with junk clocks inside it
  task automatic frame(input logic [31:0] d, input int n, input int hp,
                       output logic [7:0] rx);
    rx = 8'h00;
    cs_n_o <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      // New bit leaves with the falling edge: 30 ns clock, 15 ns setup
      si_o <= d[n-1-i];
      if (i == hp)
      begin
        // Pause pin moves only mid low phase, never on a clock edge
        #5 hold_o <= 1'b1;
        repeat (2)
        begin
          #15 sck_o <= 1'b1;
          si_o <= ~si_o;
          #15 sck_o <= 1'b0;
        end
        #5 hold_o <= 1'b0;
        si_o <= d[n-1-i];
        #10;
      end
      #15 rx = {rx[6:0], so_i};
      sck_o <= 1'b1;
      #15 sck_o <= 1'b0;
    end
    #15 cs_n_o <= 1'b1;
    si_o <= ~si_o; // Released line no longer shows the last bit
  endtask
endmodule
`default_nettype wire

// File: verification/test_serial_flash_pause_and_lock_pins.sv
// Bench: erases of every size, status reads, pauses and lock.
// Assumes the pads carry pull-ups and the host model drives the link.
`include "flash_pins_regs.svh"
`default_nettype none
module test_serial_flash_pause_and_lock_pins
  import flash_pins_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       lock_en = 1'b0;
  logic       sck, cs_n, si, hold_en, so, oe_n, busy, lact, st, dn, rf;
  erase_req_s req;
  tri1        hold_n, lock_n; // Pull-ups on both pads
  wire        so_w = oe_n ? 1'bz : so;
  int         n_mismatch = 0;
  int         checked = 0;
  logic [31:0] rnd = 32'hf4d0d04b;
  logic [7:0] rx;
  assign hold_n = hold_en ? 1'b0 : 1'bz;
  assign lock_n = lock_en ? 1'b0 : 1'bz;
  always #10 clk_i = ~clk_i;
  flash_pin_ctrl #(.PAGE_CYC(10), .BLK4_CYC(20), .BLK32_CYC(50), .CHIP_CYC(30)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
    .hold_n_i(hold_n), .lock_n_i(lock_n), .prot_base_i(`PROT_BASE_RESET), .so_o(so),
    .so_oe_n_o(oe_n), .busy_o(busy), .lock_active_o(lact), .erase_start_o(st),
    .erase_req_o(req), .erase_done_o(dn), .erase_refused_o(rf));
  spi_host_model host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_o(hold_en), .so_i(so_w));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] opc(input erase_kind_e k);
    case (k)
      ERASE_PAGE: return `CMD_ERASE_PAGE;
      ERASE_4K:   return `CMD_ERASE_4K;
      ERASE_32K:  return `CMD_ERASE_32K;
      default:    return `CMD_ERASE_CHIP;
    endcase
  endfunction
  task automatic cmp(input logic [18:0] got, input logic [18:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_done();
    repeat (60)
    begin
      @(posedge clk_i);
      #1;
      if (dn === 1'b1)
        break;
    end
    cmp(dn, 1'b1);
    @(posedge clk_i);
    #1 cmp(busy, 1'b0);
  endtask
  // Erase frame with a pause; ok says whether it must be taken
  task automatic erase(input erase_kind_e k, input logic [16:0] a, input logic ok,
                       input logic wt);
    logic seen;
    seen = 1'b0;
    rnd = lfsr(rnd);
    if (k == ERASE_CHIP)
      host.frame({24'h0, opc(k)}, 8, int'(rnd[2:0]), rx);
    else
      host.frame({opc(k), 7'h0, a}, 32, int'(rnd[4:0]), rx);
    repeat (12)
    begin
      @(posedge clk_i);
      #1;
      if (st === 1'b1)
      begin
        seen = 1'b1;
        break;
      end
    end
    cmp(seen, ok);
    if (ok)
      cmp(req.kind, k);
    if (ok && k != ERASE_CHIP)
      cmp(req.addr, a);
    if (ok && wt)
      wait_done();
    repeat (5) @(posedge clk_i);
  endtask
  task automatic status(input logic [7:0] exp);
    host.frame({16'h0, `CMD_READ_STATUS, 8'h00}, 16, 11, rx);
    cmp(rx, exp);
    repeat (5) @(posedge clk_i);
  endtask
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      erase(erase_kind_e'(i), {1'b0, rnd[15:0]}, 1'b1, 1'b1);
    end
    erase(ERASE_32K, 17'h00000, 1'b1, 1'b0);
    status(8'h01);
    wait_done();
    @(posedge clk_i) lock_en <= 1'b1;
    repeat (6) @(posedge clk_i);
    #1 cmp(lact, 1'b1);
    erase(ERASE_CHIP, 17'h0, 1'b0, 1'b1);
    cmp(rf, 1'b1);
    status(8'h06);
    erase(ERASE_PAGE, 17'h10000, 1'b0, 1'b1);
    erase(ERASE_PAGE, 17'h0ffff, 1'b1, 1'b1);
    cmp(rf, 1'b0);
    @(posedge clk_i) lock_en <= 1'b0;
    repeat (6) @(posedge clk_i);
    #1 cmp(lact, 1'b0);
    status(8'h00);
    test_done();
  end
  initial
  begin
    #200000;
    n_mismatch++;
    test_done();
  end
endmodule
`default_nettype wire
